// ---- hw/csb_pkg.sv ----
// csb_pkg: constants shared by the channel status double buffer
// assumes byte-wide control-port access to the user-side buffer
package csb_pkg;
    localparam int unsigned CSB_BYTES = 48;              // bytes per buffer
    localparam int unsigned CSB_BYTES_PER_CH = 24;       // per channel
    localparam logic [5:0] CSB_BASE_ADDR = 6'h08;        // first buffer address
    localparam logic [5:0] CSB_LAST_ADDR = 6'h37;        // last buffer address
    localparam logic [5:0] CSB_TOD_A0_ADDR = 6'h2c;      // time-of-day bytes, ch a
    localparam logic [5:0] CSB_TOD_A1_ADDR = 6'h2e;
    localparam logic [5:0] CSB_TOD_A2_ADDR = 6'h30;
    localparam logic [5:0] CSB_TOD_A3_ADDR = 6'h32;
    localparam logic [7:0] CSB_FRAMES_PER_BLOCK = 8'hc0; // 192 frames
    localparam logic [7:0] CSB_WIN_FIRST = 8'hb8;        // frame 184
    localparam logic [7:0] CSB_WIN_LAST = 8'hbf;         // frame 191
    localparam logic CSB_DISABLE_RST = 1'b0;             // transfer_disable_bit reset
    localparam logic [7:0] CSB_BYTE_RST = 8'h00;
    typedef enum logic [1:0] {
        CSB_IDLE = 2'b00,
        CSB_COPY = 2'b01,
        CSB_DONE = 2'b10
    } csb_state_t;
endpackage : csb_pkg

// ---- hw/csb_top.sv ----
// csb_top: user-side and transmitter-side channel status buffers with block copy
// assumes i_frame_sync pulses one cycle per frame and i_block_start marks frame 0
// How it works
// - with transfer_disable_bit low, copies from user to transmitter buffer happen
// - with transfer_disable_bit high no copy starts or continues
// - a copy starts only in frames 184 to 191 of a block
// - time-of-day bytes a18..a21 sit at 0x2c, 0x2e, 0x30, 0x32
// - channel a byte n at 0x08+2n, channel b byte n at next address
// - each buffer holds 48 bytes; encoder reads only the transmitter side
// - a finished copy pulses transfer_done_interrupt unless masked
// - control-port access to the user buffer is ignored during a copy
// - setting transfer_disable_bit during a copy aborts it
`timescale 1ns/1ps
module csb_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_frame_sync,
    input wire logic i_block_start,
    input wire logic i_transfer_disable_bit,
    input wire logic i_done_mask_n,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_busy,
    input wire logic i_enc_ch_b,
    input wire logic [4:0] i_enc_byte,
    output logic [7:0] o_enc_data,
    output logic o_transfer_done_interrupt,
    output logic [31:0] o_tod_a,
    output logic [7:0] o_frame
);
    import csb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // storage
    // two full copies of the block: the host edits one while the encoder reads
    // the other, so the stream carries a half-written block only after an aborted or reset copy
    // buffer index n: channel a byte n/2 when even, channel b byte n/2 when odd
    logic [7:0] user_side_buffer [CSB_BYTES];
    logic [7:0] transmitter_side_buffer [CSB_BYTES];

    // copy control and frame position
    csb_state_t state_q, state_d;
    logic [5:0] idx_q, idx_d;
    logic [7:0] frame_q, frame_d;

    // registered read ports and done pulse
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [7:0] enc_q;
    logic done_q;

    // address to buffer index; addresses outside the map give no hit
    function automatic logic [5:0] csb_index(input logic [5:0] addr);
        csb_index = addr - CSB_BASE_ADDR;
    endfunction : csb_index

    // true for the 48 mapped addresses; the rest of the port space is ignored
    function automatic logic csb_hit(input logic [5:0] addr);
        csb_hit = (addr >= CSB_BASE_ADDR) && (addr <= CSB_LAST_ADDR);
    endfunction : csb_hit

    ////////////////////////////////////////////////////////////////////////////
    // decode
    // the host port is refused, not stalled, while a copy runs:
    // a copy lasts 48 clocks and the host can watch o_busy and retry
    // the window test uses the registered frame, one clock behind the sync
    wire copying = (state_q == CSB_COPY);
    wire in_window = (frame_q >= CSB_WIN_FIRST) && (frame_q <= CSB_WIN_LAST);
    wire start_copy = (state_q == CSB_IDLE) && in_window && !i_transfer_disable_bit;
    wire abort_copy = copying && i_transfer_disable_bit;
    wire last_byte = copying && (idx_q == 6'(CSB_BYTES - 1));
    wire host_ok = !copying && csb_hit(i_addr);
    wire host_wr = i_wr && host_ok;
    wire host_rd = i_rd && host_ok;
    wire [5:0] host_idx = csb_index(i_addr);
    // interleaved layout: channel b byte follows channel a byte
    wire [5:0] enc_idx = {i_enc_byte, i_enc_ch_b};
    wire enc_ok = i_enc_byte < 5'(CSB_BYTES_PER_CH);

    ////////////////////////////////////////////////////////////////////////////
    // frame counter within a 192-frame block
    // block start wins over the wrap, so a slipped block realigns at once
    // without block starts the count keeps running and wraps after 191
    always_comb begin
        frame_d = frame_q;
        if (i_frame_sync) begin
            if (i_block_start || frame_q == CSB_FRAMES_PER_BLOCK - 8'h01) begin
                frame_d = 8'h00;
            end else begin
                frame_d = frame_q + 8'h01;
            end
        end
    end

    // copy sequencer; one byte per clock, so 48 clocks fit well inside one frame
    // done state waits out the window, so a block never sees two copies
    // an abort also lands in done: the host must wait for the next block
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        unique case (state_q)
            CSB_IDLE: begin
                idx_d = 6'h00;
                if (start_copy) begin
                    state_d = CSB_COPY;
                end
            end
            CSB_COPY: begin
                idx_d = idx_q + 6'h01;
                if (abort_copy) begin
                    state_d = CSB_DONE;
                end else if (last_byte) begin
                    state_d = CSB_DONE;
                end
            end
            CSB_DONE: begin
                // hold off until the window passes so one copy per block
                if (!in_window) begin
                    state_d = CSB_IDLE;
                end
            end
            default: state_d = CSB_IDLE;
        endcase
    end

    // sequencer state; reset stops a copy half way, the buffers keep their bytes
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= CSB_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // byte index of the running copy, also the transmitter-side write address
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idx_q <= 6'h00;
        end else begin
            idx_q <= idx_d;
        end
    end

    // frame number; zero after reset, so no copy starts until the next window
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            frame_q <= 8'h00;
        end else begin
            frame_q <= frame_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // buffers have no reset: contents are host-defined before the first copy
    // a write during a copy is dropped, never queued, so the copy stays whole
    always_ff @(posedge i_clk) begin
        if (host_wr) begin
            user_side_buffer[host_idx] <= i_wdata;
        end
    end

    // transmitter side changes only while a copy runs and the bit is clear
    // an abort keeps the bytes already moved; the rest wait for the next block
    // the write address is the sequencer index, so no other port can collide
    always_ff @(posedge i_clk) begin
        if (copying && !abort_copy) begin
            transmitter_side_buffer[idx_q] <= user_side_buffer[idx_q];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read paths and done pulse

    // host read of the user side; the data holds until the next accepted read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= CSB_BYTE_RST;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= host_rd;
            if (host_rd) begin
                rdata_q <= user_side_buffer[host_idx];
            end
        end
    end

    // encoder read of the transmitter side; a byte past the block reads as zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            enc_q <= CSB_BYTE_RST;
        end else begin
            enc_q <= enc_ok ? transmitter_side_buffer[enc_idx] : CSB_BYTE_RST;
        end
    end

    // done pulse only for a copy that reached the last byte unaborted;
    // the mask is a plain gate, a masked pulse is never held for later
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= last_byte && !abort_copy && i_done_mask_n;
        end
    end

    // time-of-day code of channel a as the encoder will send it
    // channel a byte 18 is the most significant byte of the code
    assign o_tod_a = {transmitter_side_buffer[csb_index(CSB_TOD_A0_ADDR)],
                      transmitter_side_buffer[csb_index(CSB_TOD_A1_ADDR)],
                      transmitter_side_buffer[csb_index(CSB_TOD_A2_ADDR)],
                      transmitter_side_buffer[csb_index(CSB_TOD_A3_ADDR)]};
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;
    assign o_busy = copying;
    assign o_enc_data = enc_q;
    assign o_transfer_done_interrupt = done_q;
    assign o_frame = frame_q;
endmodule : csb_top

// ---- verif/csb_host.sv ----
// csb_host: host model on the control port, byte strobes and the disable level
// assumes the bench calls acc from one process only
`timescale 1ns/1ps
module csb_host (
    input wire logic i_clk,
    output logic o_wr,
    output logic o_rd,
    output logic o_dis,
    output logic [5:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_dis, o_addr, o_wdata} = '0;
    // one access: disable level and strobe set on the same edge, strobe held one edge, data inverted once released
    task automatic acc(input logic w, input logic r, input logic dis, input logic [5:0] a,
        input logic [7:0] d);
        @(posedge i_clk);
        o_dis <= dis;
        {o_wr, o_rd, o_addr, o_wdata} <= {w, r, a, d};
        @(posedge i_clk);
        {o_wr, o_rd, o_wdata} <= {1'b0, 1'b0, ~d};
    endtask : acc
endmodule : csb_host

// ---- verif/csb_top_asserts.sv ----
// csb_top_asserts: port timing checks for the channel status double buffer
// assumes one clock domain with async active-high reset
`timescale 1ns/1ps
module csb_top_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_frame_sync,
    input wire logic i_block_start,
    input wire logic i_transfer_disable_bit,
    input wire logic i_done_mask_n,
    input wire logic i_rd,
    input wire logic [5:0] i_addr,
    input wire logic o_rvalid,
    input wire logic o_busy,
    input wire logic o_transfer_done_interrupt,
    input wire logic [7:0] o_frame
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    property p_win; $rose(o_busy) |-> $past(o_frame) inside {[8'hb8:8'hbf]}; endproperty
    a_win: assert property (p_win) else $error("copy outside frame window");
    property p_dis; $rose(o_busy) |-> !$past(i_transfer_disable_bit); endproperty
    a_dis: assert property (p_dis) else $error("copy while disabled");
    property p_abort; o_busy && i_transfer_disable_bit |=> !o_busy; endproperty
    a_abort: assert property (p_abort) else $error("copy not stopped");
    property p_busy_rd; i_rd && o_busy |=> !o_rvalid; endproperty
    a_busy_rd: assert property (p_busy_rd) else $error("read served during copy");
    property p_rvalid; i_rd && !o_busy && i_addr inside {[6'h08:6'h37]} |=> o_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_done; $fell(o_busy) && !$past(i_transfer_disable_bit) && $past(i_done_mask_n)
        |-> o_transfer_done_interrupt; endproperty
    a_done: assert property (p_done) else $error("no done pulse");
    property p_pulse; o_transfer_done_interrupt |-> $fell(o_busy) ##1 !o_transfer_done_interrupt;
    endproperty
    a_pulse: assert property (p_pulse) else $error("stray done pulse");
    property p_frm; i_frame_sync && !i_block_start && o_frame != 8'hbf
        |=> o_frame == $past(o_frame) + 8'h01; endproperty
    a_frm: assert property (p_frm) else $error("frame count wrong");
    c_done: cover property ($fell(o_busy) && o_transfer_done_interrupt);
    c_abort: cover property (o_busy && i_transfer_disable_bit);
    c_rd: cover property (i_rd && o_busy);
endmodule : csb_top_asserts

// ---- verif/csb_top_tb.sv ----
// csb_top_tb: table-driven bench for the channel status double buffer
// assumes the host model owns the control port and this bench the frame timing
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("unexpected %0t: %h not %h", $time, a, e); end end
module csb_top_tb;
    import csb_pkg::*;
    logic i_clk, i_rst, i_frame_sync, i_block_start, i_done_mask_n, i_enc_ch_b, got;
    logic i_wr, i_rd, i_transfer_disable_bit, o_rvalid, o_busy, o_transfer_done_interrupt;
    logic [5:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_enc_data, o_frame;
    logic [4:0] i_enc_byte;
    logic [31:0] o_tod_a;
    int mismatches = 0, num_checks = 0;
    // encoder select beside expected byte; user byte at addr a holds a ^ 3c
    logic [13:0] rows [7] = '{{1'b1, 5'd0, 8'h35}, {1'b0, 5'd18, 8'h10}, {1'b0, 5'd19, 8'h12},
        {1'b0, 5'd21, 8'h0e}, {1'b1, 5'd23, 8'h0b}, {1'b0, 5'd24, 8'h00}, {1'b0, 5'd0, 8'h34}};
    csb_host u_host (.i_clk(i_clk), .o_wr(i_wr), .o_rd(i_rd), .o_dis(i_transfer_disable_bit),
        .o_addr(i_addr), .o_wdata(i_wdata));
    csb_top u_dut (.*);
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // block start then 184 frames, so the count lands on the first window frame
    task automatic frames;
        for (int k = 0; k < 185; k++) begin
            @(posedge i_clk);
            {i_frame_sync, i_block_start} <= {1'b1, k == 0};
            @(posedge i_clk);
            i_frame_sync <= 1'b0;
        end
    endtask : frames
    // fixed span longer than a whole copy; records any done pulse
    task automatic wdone;
        got = 1'b0;
        repeat (60) begin
            @(posedge i_clk);
            #1 if (o_transfer_done_interrupt === 1'b1) got = 1'b1;
        end
    endtask : wdone
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        #100000;
        mismatches++;
        results();
    end
    initial begin
        {i_rst, i_frame_sync, i_block_start, i_enc_ch_b, i_enc_byte, i_done_mask_n} = 10'h201;
        repeat (3) @(posedge i_clk);
        `CHK({o_busy, o_rvalid, o_transfer_done_interrupt}, 3'b000)
        i_rst <= 1'b0;
        for (int a = 8; a < 56; a++) u_host.acc(1, 0, 1, a[5:0], a[7:0] ^ 8'h3c);
        u_host.acc(0, 0, 0, 6'h00, 8'h00);
        frames();
        #1 `CHK(o_frame, CSB_WIN_FIRST)
        u_host.acc(0, 1, 0, 6'h08, 8'h00);
        #1 `CHK(o_rvalid, 1'b0)
        u_host.acc(1, 0, 0, 6'h09, 8'h77);
        wdone();
        `CHK(got, 1'b1)
        `CHK(o_tod_a, 32'h10120c0e)
        u_host.acc(0, 1, 1, 6'h09, 8'h00);
        #1 `CHK(o_rdata, 8'h35)
        foreach (rows[r]) begin
            @(posedge i_clk);
            {i_enc_ch_b, i_enc_byte} <= rows[r][13:8];
            repeat (2) @(posedge i_clk);
            #1 `CHK(o_enc_data, rows[r][7:0])
        end
        u_host.acc(1, 0, 1, 6'h08, 8'hff);
        u_host.acc(1, 0, 1, 6'h2c, 8'ha5);
        frames();
        wdone();
        `CHK({got, o_enc_data}, 9'h034)
        `CHK(o_tod_a, 32'h10120c0e)
        // clearing the bit inside the window starts a copy; setting it again stops it
        u_host.acc(0, 0, 0, 6'h00, 8'h00);
        u_host.acc(0, 0, 1, 6'h00, 8'h00);
        wdone();
        `CHK({got, o_busy, o_tod_a}, 34'h010120c0e)
        `CHK(o_enc_data, 8'hff)
        @(posedge i_clk) i_done_mask_n <= 1'b0;
        u_host.acc(0, 0, 0, 6'h00, 8'h00);
        frames();
        wdone();
        `CHK(got, 1'b0)
        `CHK({o_enc_data, o_tod_a}, 40'hffa5120c0e)
        // reset in mid-run: control restarts, the user side keeps its bytes
        @(posedge i_clk) i_rst <= 1'b1;
        @(posedge i_clk);
        #1 `CHK({o_frame, o_busy, o_rvalid, o_transfer_done_interrupt}, 11'h000)
        @(posedge i_clk) i_rst <= 1'b0;
        u_host.acc(0, 1, 0, 6'h37, 8'h00);
        #1 `CHK({o_rvalid, o_rdata}, 9'h10b)
        results();
    end
endmodule : csb_top_tb
bind csb_top csb_top_asserts u_chk (.*);
